// ---- design/tpp_pin_cell.sv ----
module tpp_pin_cell (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  // Control from the register file.
  input  wire logic dirBit,
  input  wire logic latchBit,
  input  wire logic analogSel,
  input  wire logic slaveMode,
  // Pin.
  input  wire logic pinIn,
  output logic      pinOut,
  output logic      pinOe,
  // Value seen by a port read.
  output logic      readBit
);
  import tpp_pkg::*;

  logic pinOut_ff;
  logic pinOe_ff;

  // Driver: the direction bit rules even in analog use; slave mode turns the pin into an input.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pinOut_ff <= 1'b0;
      pinOe_ff  <= 1'b0;
    end else if (ce) begin
      pinOut_ff <= latchBit;
      pinOe_ff  <= !dirBit && !slaveMode;
    end
  end

  assign pinOut = pinOut_ff;
  assign pinOe  = pinOe_ff;

  // A read returns the pin level itself, forced to zero for an analog pin.
  assign readBit = analogSel ? 1'b0 : pinIn;

endmodule

// ---- design/tpp_pkg.sv ----
package tpp_pkg;

  // Register indices as printed; the byte address on the bus is four times the index.
  localparam logic [7:0] TPP_IDX_PORT    = 8'h09;
  localparam logic [7:0] TPP_IDX_DIR     = 8'h89;
  localparam logic [7:0] TPP_IDX_ANALOG  = 8'h9f;
  localparam logic [7:0] TPP_IDX_BITOP   = 8'hc0;
  localparam logic [7:0] TPP_IDX_IRQSTAT = 8'hc1;
  localparam logic [7:0] TPP_IDX_IRQMASK = 8'hc2;

  // Bus geometry.
  localparam int TPP_ADDR_W = 12;
  localparam int TPP_DATA_W = 32;
  localparam int TPP_PINS   = 3;

  // Direction and slave control register fields.
  localparam int TPP_DIR_IBF  = 7;
  localparam int TPP_DIR_OBF  = 6;
  localparam int TPP_DIR_INPUT_OVERFLOW_FLAG = 5;
  localparam int TPP_DIR_MODE = 4;

  // Reset values.
  localparam logic [2:0] TPP_DIR_RST    = 3'h7;
  localparam logic [2:0] TPP_ANALOG_RST = 3'h0;
  localparam logic [2:0] TPP_LATCH_RST  = 3'h0;
  localparam logic [2:0] TPP_IRQ_RST    = 3'h0;

  // Analog configuration codes that turn all three pins digital.
  localparam logic [1:0] TPP_ANALOG_DIGITAL_HI = 2'h3;

  // Bit operation register fields.
  localparam int TPP_BITOP_TGT_LO = 0;
  localparam int TPP_BITOP_IDX_LO = 2;
  localparam int TPP_BITOP_VAL    = 8;

  // Bit operation targets.
  localparam logic [1:0] TPP_TGT_PORT   = 2'h0;
  localparam logic [1:0] TPP_TGT_DIR    = 2'h1;
  localparam logic [1:0] TPP_TGT_ANALOG = 2'h2;

  // Interrupt status bits.
  localparam int TPP_IRQ_WRDONE = 0;
  localparam int TPP_IRQ_RDDONE = 1;
  localparam int TPP_IRQ_OVF    = 2;

  // Slave port sequencer states.
  typedef enum logic [2:0] {
    TPP_PSP_IDLE  = 3'b001,
    TPP_PSP_WRITE = 3'b010,
    TPP_PSP_READ  = 3'b100
  } tpp_psp_state_t;

endpackage

// ---- design/tpp_port.sv ----
// Operation
// - Each pin has its own direction bit, input or output independently.
// - Slave port select bit 4 makes the pins slave port control inputs.
// - Analog configuration register bits choose analog or digital for all three pins together.
// - An analog pin reads as zero in the port register.
// - Direction bits still drive the output drivers of analog pins.
// - After reset all three pins are analog inputs.
// - Direction bit one means input, zero output; all reset to one.
// - Unimplemented bit 3 and upper port bits read as zero.
// - Low read strobe with chip select active means an external read.
// - Low write strobe with chip select active means an external write.
// - Chip select is active low.
// - A port read returns pin levels, not the output latch.
// - A port write loads the output latch driving output pins.
// - Bit operations read the whole register, modify, then write it back.
// - Bit operations on the port write pin levels into the whole latch.
// - Outside slave mode buffer flags stay zero; overflow keeps until cleared.
module tpp_port (
  // Clock, enable and reset.
  input  wire logic                          clk,
  input  wire logic                          arst_n,
  input  wire logic                          ce,

  // APB slave.
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [tpp_pkg::TPP_ADDR_W-1:0] paddr,
  input  wire logic [tpp_pkg::TPP_DATA_W-1:0] pwdata,
  output logic      [tpp_pkg::TPP_DATA_W-1:0] prdata,
  output logic                               pready,
  output logic                               pslverr,

  // Port pins.
  input  wire logic [tpp_pkg::TPP_PINS-1:0]   pinIn,
  output logic      [tpp_pkg::TPP_PINS-1:0]   pinOut,
  output logic      [tpp_pkg::TPP_PINS-1:0]   pinOe,

  // Byte-wide data port handshake.
  input  wire logic                          cpuDataRead,
  input  wire logic                          cpuDataWritten,
  output logic                               slavePortSelect,
  output logic                               dataInLatch,
  output logic                               dataOutEnable,
  output logic                               inputBufferFullFlag,

  // Interrupt.
  output logic                               irq
);
  import tpp_pkg::*;

  // Register state.
  logic [TPP_PINS-1:0]   latch_ff;
  logic [TPP_PINS-1:0]   dir_ff;
  logic [2:0]            analogCfg_ff;
  logic                  slaveMode_ff;

  // Interrupt state and the overflow flag's history.
  logic [2:0]            irqStat_ff;
  logic [2:0]            irqMask_ff;
  logic                  irq_ff;
  logic                  ibovPrev_ff;

  // Bus answer state.
  logic [TPP_DATA_W-1:0] prdata_ff;
  logic                  pready_ff;
  logic                  pslverr_ff;

  // Output stage for the byte port.
  logic                  dataInLatch_ff;
  logic                  dataOutEnable_ff;
  logic                  ibfOut_ff;
  logic                  modeOut_ff;

  // Internal nets.
  logic [TPP_PINS-1:0]   pinRead;
  logic [TPP_PINS-1:0]   analogPin;

  // Slave port flags and events.
  logic                  input_buffer_full_flag;
  logic                  output_buffer_full_flag;
  logic                  input_overflow_flag;
  logic                  wrDone;
  logic                  rdDone;
  logic                  rdActive;

  // Bus decode.
  logic                  access;
  logic                  setupRd;
  logic [7:0]            regIdx;
  logic                  addrOk;
  logic                  mapped;
  logic                  busWr;

  // Write path shared by plain writes and bit operations.
  logic                  doWrite;
  logic [7:0]            wrIdx;
  logic [7:0]            wrVal;

  // Bit operation path.
  logic [7:0]            rmwSrc;
  logic [7:0]            rmwRes;
  logic [2:0]            rmwBit;
  logic [1:0]            rmwTgt;

  // Interrupt sources.
  logic [2:0]            irqEvents;
  logic                  ovfEvent;

  // Every analog configuration code except the two digital ones leaves all pins analog.
  function automatic logic isAnalog(input logic [2:0] cfg);
    isAnalog = (cfg[2:1] != TPP_ANALOG_DIGITAL_HI);
  endfunction

  // Read view of a register as the local processor sees it.
  function automatic logic [7:0] readView(input logic [7:0] idx, input logic [2:0] pins,
                                          input logic [2:0] dir, input logic [2:0] acfg,
                                          input logic mode, input logic fIbf,
                                          input logic fObf, input logic fIbov);
    readView = 8'h00;
    unique case (idx)
      TPP_IDX_PORT:   readView = {5'h00, pins};
      TPP_IDX_DIR:    readView = {fIbf, fObf, fIbov, mode, 1'b0, dir};
      TPP_IDX_ANALOG: readView = {5'h00, acfg};
      default:        readView = 8'h00;
    endcase
  endfunction

  // Address decode: word aligned, upper bits clear, index within the map.
  assign regIdx = paddr[9:2];
  assign addrOk = (paddr[1:0] == 2'h0) && (paddr[TPP_ADDR_W-1:10] == 2'h0);
  assign mapped = addrOk && ((regIdx == TPP_IDX_PORT) || (regIdx == TPP_IDX_DIR) ||
                             (regIdx == TPP_IDX_ANALOG) || (regIdx == TPP_IDX_BITOP) ||
                             (regIdx == TPP_IDX_IRQSTAT) || (regIdx == TPP_IDX_IRQMASK));

  // The access completes at the edge that sees pready high.
  assign access  = psel && penable && pready_ff;
  assign setupRd = psel && penable && !pready_ff;
  // A mapped write lands at that same edge and at no other.
  assign busWr   = access && pwrite && mapped;

  // One analog selection for all pins from the configuration register.
  assign analogPin = {TPP_PINS{isAnalog(analogCfg_ff)}};

  // Pin cells. Each pin has a cell of its own, so each direction bit acts alone,
  // whatever the analog selection of the pins.
  genvar gi;
  generate
    for (gi = 0; gi < TPP_PINS; gi++) begin : gPin
      tpp_pin_cell uCell (
        .clk       (clk),
        .arst_n    (arst_n),
        .ce        (ce),
        .dirBit    (dir_ff[gi]),
        .latchBit  (latch_ff[gi]),
        .analogSel (analogPin[gi]),
        .slaveMode (slaveMode_ff),
        .pinIn     (pinIn[gi]),
        .pinOut    (pinOut[gi]),
        .pinOe     (pinOe[gi]),
        .readBit   (pinRead[gi])
      );
    end
  endgenerate

  // Slave port sequencer; pin 0 reads, pin 1 writes, pin 2 selects.
  tpp_psp_ctrl uPsp (
    .clk              (clk),
    .arst_n           (arst_n),
    .ce               (ce),
    .slaveMode        (slaveMode_ff),
    .rdStrobeN        (pinIn[0]),
    .wrStrobeN        (pinIn[1]),
    .chipSelN         (pinIn[2]),
    .cpuDataRead      (cpuDataRead),
    .cpuDataWritten   (cpuDataWritten),
    .ovfWrEn          (doWrite && (wrIdx == TPP_IDX_DIR)),
    .ovfWrVal         (wrVal[TPP_DIR_INPUT_OVERFLOW_FLAG]),
    .inputBufferFull  (input_buffer_full_flag),
    .outputBufferFull (output_buffer_full_flag),
    .inputOverflow    (input_overflow_flag),
    .writeDone        (wrDone),
    .readDone         (rdDone),
    .readActive       (rdActive)
  );

  // Bit operation: read the whole target, change one bit, write the whole result back.
  assign rmwTgt = pwdata[TPP_BITOP_TGT_LO +: 2];
  assign rmwBit = pwdata[TPP_BITOP_IDX_LO +: 3];
  always_comb begin
    unique case (rmwTgt)
      TPP_TGT_PORT:   rmwSrc = readView(TPP_IDX_PORT, pinRead, dir_ff, analogCfg_ff,
                                        slaveMode_ff, input_buffer_full_flag, output_buffer_full_flag, input_overflow_flag);
      TPP_TGT_DIR:    rmwSrc = readView(TPP_IDX_DIR, pinRead, dir_ff, analogCfg_ff,
                                        slaveMode_ff, input_buffer_full_flag, output_buffer_full_flag, input_overflow_flag);
      TPP_TGT_ANALOG: rmwSrc = readView(TPP_IDX_ANALOG, pinRead, dir_ff, analogCfg_ff,
                                        slaveMode_ff, input_buffer_full_flag, output_buffer_full_flag, input_overflow_flag);
      default:        rmwSrc = 8'h00;
    endcase
    rmwRes         = rmwSrc;
    rmwRes[rmwBit] = pwdata[TPP_BITOP_VAL];
  end

  // One write path serves plain writes and bit operations alike.
  always_comb begin
    doWrite = 1'b0;
    wrIdx   = regIdx;
    wrVal   = pwdata[7:0];
    if (busWr) begin
      if (regIdx == TPP_IDX_BITOP) begin
        doWrite = (rmwTgt != 2'h3);
        wrIdx   = (rmwTgt == TPP_TGT_PORT) ? TPP_IDX_PORT :
                  (rmwTgt == TPP_TGT_DIR)  ? TPP_IDX_DIR  : TPP_IDX_ANALOG;
        wrVal   = rmwRes;
      end else begin
        doWrite = 1'b1;
      end
    end
  end

  // Output latch of the port.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_ff <= TPP_LATCH_RST;
    end else if (ce && doWrite && (wrIdx == TPP_IDX_PORT)) begin
      latch_ff <= wrVal[TPP_PINS-1:0];
    end
  end

  // Direction bits and slave port select; the flag bits are owned by the sequencer.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dir_ff       <= TPP_DIR_RST;
      slaveMode_ff <= 1'b0;
    end else if (ce && doWrite && (wrIdx == TPP_IDX_DIR)) begin
      dir_ff       <= wrVal[TPP_PINS-1:0];
      slaveMode_ff <= wrVal[TPP_DIR_MODE];
    end
  end

  // Analog configuration; reset leaves every pin analog.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      analogCfg_ff <= TPP_ANALOG_RST;
    end else if (ce && doWrite && (wrIdx == TPP_IDX_ANALOG)) begin
      analogCfg_ff <= wrVal[2:0];
    end
  end

  // Interrupt events. Overflow counts only where the flag rises as a write finishes,
  // so an old uncleared flag raises no new event; a firmware write raises one only if it sets the flag as a write finishes.
  assign ovfEvent  = wrDone && input_overflow_flag && !ibovPrev_ff;
  assign irqEvents = {ovfEvent, rdDone, wrDone};

  // Overflow flag as it stood a cycle ago, to tell a new overflow from an old one.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ibovPrev_ff <= 1'b0;
    end else if (ce) begin
      ibovPrev_ff <= input_overflow_flag;
    end
  end

  // Sticky status, write one to clear; a new event in the clearing cycle stays set.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqStat_ff <= TPP_IRQ_RST;
    end else if (ce) begin
      if (busWr && (regIdx == TPP_IDX_IRQSTAT)) begin
        irqStat_ff <= (irqStat_ff & ~pwdata[2:0]) | irqEvents;
      end else begin
        irqStat_ff <= irqStat_ff | irqEvents;
      end
    end
  end

  // Interrupt mask, one bit per status bit.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqMask_ff <= TPP_IRQ_RST;
    end else if (ce && busWr && (regIdx == TPP_IDX_IRQMASK)) begin
      irqMask_ff <= pwdata[2:0];
    end
  end

  // The level output follows status one cycle later, which keeps it glitch free.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_ff <= 1'b0;
    end else if (ce) begin
      irq_ff <= |(irqStat_ff & irqMask_ff);
    end
  end

  // APB answer: one wait state, read data captured at the edge that raises pready.
  // With ce low the answer freezes with the rest; a low pready stretches the transfer, but a high pready stays high and a write taken then is lost.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= '0;
    end else if (ce) begin
      pready_ff  <= setupRd;
      pslverr_ff <= setupRd && !mapped;
      if (setupRd && !pwrite) begin
        unique case (regIdx)
          TPP_IDX_IRQSTAT: prdata_ff <= {29'h0, irqStat_ff};
          TPP_IDX_IRQMASK: prdata_ff <= {29'h0, irqMask_ff};
          default:         prdata_ff <= {24'h0, readView(regIdx, pinRead, dir_ff,
                                             analogCfg_ff, slaveMode_ff, input_buffer_full_flag, output_buffer_full_flag, input_overflow_flag)};
        endcase
        if (!mapped) begin
          prdata_ff <= '0;
        end
      end
    end
  end

  // Registered handshake outputs toward the byte-wide data port.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dataInLatch_ff   <= 1'b0;
      dataOutEnable_ff <= 1'b0;
      ibfOut_ff        <= 1'b0;
      modeOut_ff       <= 1'b0;
    end else if (ce) begin
      // A write that finishes as the mode is left is not passed on.
      dataInLatch_ff   <= wrDone && slaveMode_ff;
      dataOutEnable_ff <= rdActive;
      ibfOut_ff        <= input_buffer_full_flag;
      modeOut_ff       <= slaveMode_ff;
    end
  end

  assign prdata              = prdata_ff;
  assign pready              = pready_ff;
  assign pslverr             = pslverr_ff;
  assign slavePortSelect     = modeOut_ff;
  assign dataInLatch         = dataInLatch_ff;
  assign dataOutEnable       = dataOutEnable_ff;
  assign inputBufferFullFlag = ibfOut_ff;
  assign irq                 = irq_ff;

endmodule

// ---- design/tpp_psp_ctrl.sv ----
module tpp_psp_ctrl (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic ce,
  // Mode and strobe pin levels.
  input  wire logic slaveMode,
  input  wire logic rdStrobeN,
  input  wire logic wrStrobeN,
  input  wire logic chipSelN,
  // Local side of the byte-wide data port.
  input  wire logic cpuDataRead,
  input  wire logic cpuDataWritten,
  // Firmware access to the overflow flag.
  input  wire logic ovfWrEn,
  input  wire logic ovfWrVal,
  // Flags and events.
  output logic      inputBufferFull,
  output logic      outputBufferFull,
  output logic      inputOverflow,
  output logic      writeDone,
  output logic      readDone,
  output logic      readActive
);
  import tpp_pkg::*;

  tpp_psp_state_t state_ff;
  logic           ibf_ff;
  logic           obf_ff;
  logic           input_overflow_flag_ff;
  logic           wrDone_ff;
  logic           rdDone_ff;
  logic           wrSel;
  logic           rdSel;

  // Strobes count only while chip select is low.
  assign wrSel = slaveMode && !chipSelN && !wrStrobeN;
  assign rdSel = slaveMode && !chipSelN && !rdStrobeN;

  // Sequencer: a transfer starts at the first low sample and ends when either line rises.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= TPP_PSP_IDLE;
    end else if (ce) begin
      unique case (state_ff)
        TPP_PSP_IDLE: begin
          if (wrSel) begin
            state_ff <= TPP_PSP_WRITE;
          end else if (rdSel) begin
            state_ff <= TPP_PSP_READ;
          end
        end
        TPP_PSP_WRITE: begin
          if (!wrSel) begin
            state_ff <= TPP_PSP_IDLE;
          end
        end
        TPP_PSP_READ: begin
          if (!rdSel) begin
            state_ff <= TPP_PSP_IDLE;
          end
        end
      endcase
    end
  end

  // Completion pulses, one cycle each; a transfer cut off by leaving the mode reports none.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wrDone_ff <= 1'b0;
      rdDone_ff <= 1'b0;
    end else if (ce) begin
      wrDone_ff <= slaveMode && (state_ff == TPP_PSP_WRITE) && !wrSel;
      rdDone_ff <= slaveMode && (state_ff == TPP_PSP_READ) && !rdSel;
    end
  end

  // Buffer flags; a completing transfer wins over a local clear in the same cycle.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ibf_ff  <= 1'b0;
      obf_ff  <= 1'b0;
      input_overflow_flag_ff <= 1'b0;
    end else if (ce) begin
      if (!slaveMode) begin
        ibf_ff <= 1'b0;
        obf_ff <= 1'b0;
      end else begin
        if ((state_ff == TPP_PSP_WRITE) && !wrSel) begin
          ibf_ff <= 1'b1;
        end else if (cpuDataRead) begin
          ibf_ff <= 1'b0;
        end
        if ((state_ff == TPP_PSP_IDLE) && !wrSel && rdSel) begin
          obf_ff <= 1'b0;
        end else if (cpuDataWritten) begin
          obf_ff <= 1'b1;
        end
      end
      // Overflow survives mode changes and only firmware clears it.
      if (slaveMode && ibf_ff && !cpuDataRead && (state_ff == TPP_PSP_WRITE) && !wrSel) begin
        input_overflow_flag_ff <= 1'b1;
      end else if (ovfWrEn) begin
        input_overflow_flag_ff <= ovfWrVal;
      end
    end
  end

  assign inputBufferFull  = ibf_ff;
  assign outputBufferFull = obf_ff;
  assign inputOverflow    = input_overflow_flag_ff;
  assign writeDone        = wrDone_ff;
  assign readDone         = rdDone_ff;
  assign readActive       = (state_ff == TPP_PSP_READ);

endmodule

// ---- tb/tpp_ext_model.sv ----
module tpp_ext_model (
  // Pin side of the port.
  input  wire logic [tpp_pkg::TPP_PINS-1:0] pinOut,
  input  wire logic [tpp_pkg::TPP_PINS-1:0] pinOe,
  // Outside levels: bit0 read, bit1 write, bit2 select, all low active.
  input  wire logic [tpp_pkg::TPP_PINS-1:0] extLevel,
  output logic      [tpp_pkg::TPP_PINS-1:0] pinIn
);
  timeunit 1ns;
  timeprecision 1ps;
  import tpp_pkg::*;

  // The outside drives only released pins, so a driven pin never fights it.
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
endmodule

// ---- tb/tpp_port_bench.sv ----
module tpp_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import tpp_pkg::*;
  typedef struct packed {logic w; logic [7:0] idx; logic [31:0] d;} tpp_row_t;
  // Writes carry data, reads carry the expected word.
  localparam tpp_row_t ROWS [15] = '{
    '{1'b0, TPP_IDX_DIR, 32'h7}, '{1'b0, TPP_IDX_ANALOG, 32'h0}, '{1'b0, TPP_IDX_PORT, 32'h0},
    '{1'b1, TPP_IDX_ANALOG, 32'h6}, '{1'b0, TPP_IDX_ANALOG, 32'h6}, '{1'b0, TPP_IDX_PORT, 32'h5},
    '{1'b1, TPP_IDX_PORT, 32'h2}, '{1'b0, TPP_IDX_PORT, 32'h5}, '{1'b1, TPP_IDX_DIR, 32'h0},
    '{1'b0, TPP_IDX_PORT, 32'h2}, '{1'b1, TPP_IDX_DIR, 32'he}, '{1'b0, TPP_IDX_DIR, 32'h6},
    '{1'b0, TPP_IDX_PORT, 32'h4}, '{1'b0, TPP_IDX_IRQMASK, 32'h0}, '{1'b0, TPP_IDX_IRQSTAT, 32'h0}};
  logic        clk = 1'b0, arst_n = 1'b0, ce = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [2:0]  pinIn, pinOut, pinOe, extLevel = 3'h5;
  logic        cpuDataRead = 1'b0, cpuDataWritten = 1'b0, irq;
  logic        slavePortSelect, dataInLatch, dataOutEnable, inputBufferFullFlag;
  int          errCount = 0, checks = 0, latchCnt = 0, rdCnt = 0;

  tpp_port DUT (.clk, .arst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pinIn, .pinOut, .pinOe, .cpuDataRead, .cpuDataWritten, .slavePortSelect,
    .dataInLatch, .dataOutEnable, .inputBufferFullFlag, .irq);
  tpp_ext_model uExt (.pinOut, .pinOe, .extLevel, .pinIn);

  // Clock at 200 MHz.
  always #2.5 clk = ~clk;
  // Counting dataInLatch pulses and dataOutEnable high cycles means none is missed whatever the wait after a strobe.
  always @(posedge clk) begin
    if (dataInLatch === 1'b1) latchCnt <= latchCnt + 1;
    if (dataOutEnable === 1'b1) rdCnt <= rdCnt + 1;
  end

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Waits for pready however long; only the watchdog ends a hung wait.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     output logic [31:0] rd, output logic se);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'h0, idx, 2'h0};
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    cyc(4);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] rd;
    logic        se;
    apb(1'b1, idx, d, rd, se);
  endtask
  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] rd;
    logic        se;
    apb(1'b0, idx, 32'h0, rd, se);
    chk({se, rd}, {1'b0, exp});
  endtask
  // One strobe pattern for three cycles, then all lines idle high.
  task automatic ext(input logic [2:0] v);
    extLevel <= v;
    cyc(3);
    extLevel <= 3'h7;
    cyc(4);
  endtask
  task automatic finish_test;
    $display("Checks %0d, mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Watchdog well beyond the few hundred cycles the run needs.
  initial begin
    #50000;
    errCount++;
    finish_test();
  end

  initial begin
    logic [31:0] rd;
    logic        se;
    cyc(16);
    arst_n <= 1'b1;
    cyc(1);
    chk(pinOe, 33'h0);
    for (int i = 0; i < 15; i++) begin
      apb(ROWS[i].w, ROWS[i].idx, ROWS[i].d, rd, se);
      if (ROWS[i].w) chk(se, 33'h0);
      else chk({se, rd}, {1'b0, ROWS[i].d});
    end
    apb(1'b1, 8'h10, 32'hff, rd, se);
    chk(se, 33'h1);
    apb(1'b0, 8'h10, 32'h0, rd, se);
    chk({se, rd}, {1'b1, 32'h0});
    // Pins read 100 while the latch holds 010; setting bit 0 stores 101.
    wr(TPP_IDX_BITOP, 32'h100);
    wr(TPP_IDX_DIR, 32'h0);
    rdc(TPP_IDX_PORT, 32'h5);
    wr(TPP_IDX_BITOP, 32'h109);
    rdc(TPP_IDX_DIR, 32'h4);
    wr(TPP_IDX_ANALOG, 32'h0);
    wr(TPP_IDX_DIR, 32'h0);
    chk(pinOe, 33'h7);
    rdc(TPP_IDX_PORT, 32'h0);
    // Slave port traffic with pins digital and inputs first.
    extLevel <= 3'h7;
    wr(TPP_IDX_ANALOG, 32'h6);
    wr(TPP_IDX_DIR, 32'h17);
    chk({slavePortSelect, pinOe}, 33'h8);
    rdc(TPP_IDX_DIR, 32'h17);
    ext(3'h1);
    chk({inputBufferFullFlag, latchCnt[7:0]}, 33'h101);
    rdc(TPP_IDX_IRQSTAT, 32'h1);
    ext(3'h1);
    rdc(TPP_IDX_DIR, 32'hb7);
    ext(3'h5);
    ce <= 1'b0;
    ext(3'h1);
    ce <= 1'b1;
    chk(latchCnt, 33'h2);
    cpuDataRead <= 1'b1;
    cyc(1);
    cpuDataRead <= 1'b0;
    cpuDataWritten <= 1'b1;
    cyc(1);
    cpuDataWritten <= 1'b0;
    rdc(TPP_IDX_DIR, 32'h77);
    ext(3'h2);
    chk(rdCnt, 33'h3);
    rdc(TPP_IDX_DIR, 32'h37);
    rdc(TPP_IDX_IRQSTAT, 32'h7);
    chk(irq, 33'h0);
    wr(TPP_IDX_IRQMASK, 32'h2);
    chk(irq, 33'h1);
    wr(TPP_IDX_IRQSTAT, 32'h7);
    chk(irq, 33'h0);
    rdc(TPP_IDX_IRQSTAT, 32'h0);
    ext(3'h1);
    wr(TPP_IDX_DIR, 32'h27);
    ext(3'h1);
    chk(latchCnt, 33'h3);
    rdc(TPP_IDX_DIR, 32'h27);
    // Reset in mid-run with all pins driven.
    wr(TPP_IDX_DIR, 32'h20);
    arst_n <= 1'b0;
    cyc(2);
    chk({irq, slavePortSelect, inputBufferFullFlag, pready, pinOe}, 33'h0);
    arst_n <= 1'b1;
    cyc(1);
    rdc(TPP_IDX_DIR, 32'h7);
    rdc(TPP_IDX_ANALOG, 32'h0);
    finish_test();
  end
endmodule

// ---- tb/tpp_port_checker.sv ----
module tpp_port_checker (
  // Clock and reset.
  input wire logic                          clk,
  input wire logic                          arst_n,
  input wire logic                          ce,
  // Bus.
  input wire logic                          psel,
  input wire logic                          penable,
  input wire logic [tpp_pkg::TPP_ADDR_W-1:0] paddr,
  input wire logic                          pready,
  input wire logic                          pslverr,
  // Pins and slave port flags.
  input wire logic [tpp_pkg::TPP_PINS-1:0]  pinOe,
  input wire logic                          slavePortSelect,
  input wire logic                          dataInLatch,
  input wire logic                          inputBufferFullFlag
);
  timeunit 1ns;
  timeprecision 1ps;
  import tpp_pkg::*;
  logic mapped;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Only the six decoded words may answer without an error.
  assign mapped = paddr inside {12'h024, 12'h224, 12'h27c, 12'h300, 12'h304, 12'h308};

  a_ready_one_wait: assert property (ce && psel && penable && !pready |=> pready)
    else $error("bus answer missed its single wait state");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("bus answer stood longer than one cycle");
  a_idle_no_ready: assert property (ce && !(psel && penable) |=> !pready)
    else $error("bus answered without an access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag outside an answer");
  a_unmapped_err: assert property (psel && penable && pready && !mapped |-> pslverr)
    else $error("unmapped address answered without error");
  a_mapped_no_err: assert property (psel && penable && pready && mapped |-> !pslverr)
    else $error("mapped address answered with error");
  a_slave_no_drive: assert property (slavePortSelect && $past(slavePortSelect) |-> pinOe == '0)
    else $error("pin driven in slave port mode");
  a_flags_off_mode: assert property (!slavePortSelect && !$past(slavePortSelect)
    && !$past(slavePortSelect, 2) |-> !inputBufferFullFlag)
    else $error("input full flag set outside slave mode");
  a_latch_one_pulse: assert property (dataInLatch |=> !dataInLatch)
    else $error("latch pulse longer than one cycle");
  a_latch_sets_full: assert property (dataInLatch |-> inputBufferFullFlag)
    else $error("latch pulse without input full flag");
  a_latch_in_mode: assert property (dataInLatch |-> slavePortSelect)
    else $error("external write taken outside slave mode");
endmodule

bind tpp_port tpp_port_checker uChk (.clk, .arst_n, .ce, .psel, .penable, .paddr, .pready,
  .pslverr, .pinOe, .slavePortSelect, .dataInLatch, .inputBufferFullFlag);
